// ==== id_rev_mask_pkg.sv ====
// constants for the identification, revision and channel interrupt mask registers
// ****************************************************************************
// Overview of operation
// [RULE_01] identification register is eight read-only bits of fixed maker code; writes ignored
// [RULE_02] revision low nibble is read-only minor revision, coded as revision number minus one
// [RULE_03] revision high nibble is read-only fixed value naming the device generation
// [RULE_04] first mask bit 0 blocks remote temp a, bit 1 remote temp b / analog in nine
// [RULE_05] first mask bit 2 blocks standby rail, bit 3 blocks main 3.3 V rail
// [RULE_06] first mask bits 4..7 block +5 V, cpu core, +12 V, -12 V rails in order
// [RULE_07] second mask bits 0..4 block analog inputs 0..4 respectively
// [RULE_08] both mask registers reset to zero so every channel starts unmasked
// [RULE_09] mask only blocks the interrupt contribution, never measurement or limit comparison
// ****************************************************************************
package id_rev_mask_pkg;

  // ****************************************************************************
  // register map
  // ****************************************************************************
  localparam int unsigned ADDR_W            = 8;
  localparam int unsigned DATA_W            = 8;
  localparam logic [7:0]  MAKER_ID_ADDR     = 8'h16;
  localparam logic [7:0]  REVISION_ADDR     = 8'h17;
  localparam logic [7:0]  MASK_FIRST_ADDR   = 8'h18;
  localparam logic [7:0]  MASK_SECOND_ADDR  = 8'h19;
  localparam logic [7:0]  UNMAPPED_RDATA    = 8'h00;

  // ****************************************************************************
  // reset values and field positions
  // ****************************************************************************
  localparam logic [7:0]  MASK_RESET        = 8'h00;
  localparam int unsigned REV_MINOR_LSB     = 0;
  localparam int unsigned REV_MAJOR_LSB     = 4;
  localparam int unsigned NIBBLE_W          = 4;

  // ****************************************************************************
  // channel positions in the 16-bit alarm vector
  // ****************************************************************************
  localparam int unsigned NUM_CHAN          = 16;
  localparam int unsigned CH_REMOTE_TEMP_A  = 0;
  localparam int unsigned CH_REMOTE_TEMP_B  = 1;
  localparam int unsigned CH_STANDBY_RAIL   = 2;
  localparam int unsigned CH_MAIN_RAIL      = 3;
  localparam int unsigned CH_PLUS5_RAIL     = 4;
  localparam int unsigned CH_CPU_CORE_RAIL  = 5;
  localparam int unsigned CH_PLUS12_RAIL    = 6;
  localparam int unsigned CH_MINUS12_RAIL   = 7;
  localparam int unsigned CH_ANALOG_IN_BASE = 8;

endpackage

// ==== irq_mask_byte.sv ====
// one eight-bit read-write mask register with write strobe
`timescale 1ns/100ps
module irq_mask_byte (
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       wr_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] mask_o
);

  typedef struct packed {
    logic [7:0] mask;
  } state_t;

  state_t state_reg;
  state_t state_next;

  // load on a decoded write only
  always_comb begin
    state_next = state_reg;
    if (wr_i) begin
      state_next.mask = wdata_i;
    end
  end

  // power-on value leaves every channel unmasked
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg.mask <= id_rev_mask_pkg::MASK_RESET; // RULE_08
    end else begin
      state_reg <= state_next;
    end
  end

  assign mask_o = state_reg.mask;

endmodule // irq_mask_byte

// ==== irq_channel_gate.sv ====
// per-channel gating of limit alarms by mask bits into one interrupt request
`timescale 1ns/100ps
module irq_channel_gate (
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  input  wire logic [15:0] alarm_i,
  input  wire logic [15:0] mask_i,
  output logic      [15:0] pending_o,
  output logic             irq_o
);

  typedef struct packed {
    logic [15:0] pending;
    logic        irq;
  } state_t;

  state_t      state_reg;
  state_t      state_next;
  logic [15:0] gated;

  // a set mask bit removes only that channel's share of the request
  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_chan
      assign gated[g] = alarm_i[g] & ~mask_i[g]; // RULE_09
    end
  endgenerate

  // register so the request pin is glitch free
  always_comb begin
    state_next         = state_reg;
    state_next.pending = gated;
    state_next.irq     = |gated;
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign pending_o = state_reg.pending;
  assign irq_o     = state_reg.irq;

endmodule // irq_channel_gate

// ==== id_rev_and_irq_mask_regs.sv ====
// identification, revision and channel interrupt mask register bank
`timescale 1ns/100ps
module id_rev_and_irq_mask_regs #(
  parameter logic [7:0] MAKER_CODE      = 8'h5A, // arbitrary value
  parameter logic [3:0] GENERATION_CODE = 4'h9,  // arbitrary value
  parameter int unsigned REVISION_NUMBER = 1     // silicon revision, counted from one
) (
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_rd_i,
  output logic      [7:0]  reg_rdata_o,
  output logic             reg_rdata_valid_o,
  input  wire logic [15:0] chan_alarm_i,
  output logic      [15:0] chan_alarm_o,
  output logic      [15:0] chan_irq_pending_o,
  output logic             irq_request_o
);

  // ****************************************************************************
  // identity constants
  // ****************************************************************************
  // minor nibble is stored as revision minus one, so revision 1 reads 0
  localparam logic [3:0] MINOR_CODE    = 4'(REVISION_NUMBER - 1); // RULE_02
  localparam logic [7:0] REVISION_BYTE = {GENERATION_CODE, MINOR_CODE}; // RULE_03

  // ****************************************************************************
  // state
  // ****************************************************************************
  typedef struct packed {
    logic [7:0]  rdata;
    logic        rvalid;
    logic [15:0] alarm;
  } state_t;

  state_t      state_reg;
  state_t      state_next;
  logic [7:0]  mask_first;
  logic [7:0]  mask_second;
  logic        wr_mask_first;
  logic        wr_mask_second;
  logic [7:0]  read_value;

  // ****************************************************************************
  // write decode
  // ****************************************************************************
  // only the two mask registers accept writes; identity and revision
  // addresses simply have no write strobe, so a write there is dropped
  assign wr_mask_first  = reg_wr_i && (reg_addr_i == id_rev_mask_pkg::MASK_FIRST_ADDR);  // RULE_04
  assign wr_mask_second = reg_wr_i && (reg_addr_i == id_rev_mask_pkg::MASK_SECOND_ADDR); // RULE_07

  irq_mask_byte u_mask_first (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .wr_i      (wr_mask_first),
    .wdata_i   (reg_wdata_i),
    .mask_o    (mask_first)
  );

  irq_mask_byte u_mask_second (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .wr_i      (wr_mask_second),
    .wdata_i   (reg_wdata_i),
    .mask_o    (mask_second)
  );

  // ****************************************************************************
  // read multiplexer
  // ****************************************************************************
  // unmapped addresses answer zero rather than stale data
  always_comb begin
    case (reg_addr_i)
      id_rev_mask_pkg::MAKER_ID_ADDR:    read_value = MAKER_CODE;    // RULE_01
      id_rev_mask_pkg::REVISION_ADDR:    read_value = REVISION_BYTE; // RULE_02 RULE_03
      id_rev_mask_pkg::MASK_FIRST_ADDR:  read_value = mask_first;
      id_rev_mask_pkg::MASK_SECOND_ADDR: read_value = mask_second;
      default:                           read_value = id_rev_mask_pkg::UNMAPPED_RDATA;
    endcase
  end

  // ****************************************************************************
  // next state
  // ****************************************************************************
  // read data is held until the next read so a slow serial engine can
  // shift it out; the raw alarm copy never looks at the masks
  always_comb begin
    state_next        = state_reg;
    state_next.rvalid = reg_rd_i;
    if (reg_rd_i) begin
      state_next.rdata = read_value;
    end
    state_next.alarm = chan_alarm_i; // RULE_09
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************************************************
  // interrupt gating
  // ****************************************************************************
  // first mask covers the temperature and rail channels, second the analog inputs
  irq_channel_gate u_gate (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .alarm_i   (chan_alarm_i),
    .mask_i    ({mask_second, mask_first}), // RULE_04 RULE_05 RULE_06 RULE_07
    .pending_o (chan_irq_pending_o),
    .irq_o     (irq_request_o)
  );

  assign reg_rdata_o       = state_reg.rdata;
  assign reg_rdata_valid_o = state_reg.rvalid;
  assign chan_alarm_o      = state_reg.alarm;

  // ****************************************************************************
  // checks
  // ****************************************************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  // helper: has any mask write happened since reset
  logic any_mask_wr_reg;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      any_mask_wr_reg <= 1'b0;
    end else if (wr_mask_first || wr_mask_second) begin
      any_mask_wr_reg <= 1'b1;
    end
  end

  sequence s_read_at(logic [7:0] a);
    reg_rd_i && !reg_wr_i && (reg_addr_i == a);
  endsequence

  sequence s_write_first;
    reg_wr_i && (reg_addr_i == id_rev_mask_pkg::MASK_FIRST_ADDR) && !reg_rd_i;
  endsequence

  a_maker_code_fixed: assert property ( // RULE_01
    s_read_at(id_rev_mask_pkg::MAKER_ID_ADDR) |=> reg_rdata_valid_o && (reg_rdata_o == MAKER_CODE))
    else $error("identification register read wrong code");

  // the host leaves one idle cycle between strobes, so the read follows two edges later
  a_maker_write_drop: assert property ( // RULE_01
    (reg_wr_i && reg_addr_i == id_rev_mask_pkg::MAKER_ID_ADDR) ##2
    s_read_at(id_rev_mask_pkg::MAKER_ID_ADDR) |=> (reg_rdata_o == MAKER_CODE))
    else $error("write changed identification register");

  a_rev_minor_code: assert property ( // RULE_02
    s_read_at(id_rev_mask_pkg::REVISION_ADDR) |=> (reg_rdata_o[3:0] == 4'(REVISION_NUMBER - 1)))
    else $error("minor revision nibble wrong");

  a_rev_major_code: assert property ( // RULE_03
    s_read_at(id_rev_mask_pkg::REVISION_ADDR) |=> (reg_rdata_o[7:4] == GENERATION_CODE))
    else $error("generation nibble wrong");

  // no other write may sit in the idle cycle, or the readback would be of that one
  a_first_mask_readback: assert property ( // RULE_04
    s_write_first ##1 !reg_wr_i ##1 s_read_at(id_rev_mask_pkg::MASK_FIRST_ADDR)
    |=> (reg_rdata_o == $past(reg_wdata_i, 3)))
    else $error("first mask did not read back written value");

  a_temp_gate: assert property ( // RULE_04
    chan_irq_pending_o[1:0] == ($past(chan_alarm_i[1:0]) & ~$past(mask_first[1:0])))
    else $error("temperature channel gating wrong");

  a_rail_gate_low: assert property ( // RULE_05
    chan_irq_pending_o[3:2] == ($past(chan_alarm_i[3:2]) & ~$past(mask_first[3:2])))
    else $error("3.3 V rail gating wrong");

  a_rail_gate_high: assert property ( // RULE_06
    chan_irq_pending_o[7:4] == ($past(chan_alarm_i[7:4]) & ~$past(mask_first[7:4])))
    else $error("upper rail gating wrong");

  a_analog_gate: assert property ( // RULE_07
    chan_irq_pending_o[12:8] == ($past(chan_alarm_i[12:8]) & ~$past(mask_second[4:0])))
    else $error("analog input gating wrong");

  a_masks_reset_zero: assert property ( // RULE_08
    !any_mask_wr_reg |-> (mask_first == 8'h00) && (mask_second == 8'h00) && $stable(mask_first))
    else $error("mask not zero before first write");

  a_alarm_unmasked: assert property ( // RULE_09
    (chan_alarm_o == $past(chan_alarm_i)) && (irq_request_o == |chan_irq_pending_o))
    else $error("mask disturbed raw alarm or request");

endmodule // id_rev_and_irq_mask_regs

// ==== reg_host_model.sv ====
// host-side model that issues single-byte register reads and writes over the strobe port
`timescale 1ns/100ps
module reg_host_model (
  input  wire logic       clk_i,
  output logic      [7:0] reg_addr_o,
  output logic            reg_wr_o,
  output logic      [7:0] reg_wdata_o,
  output logic            reg_rd_o
);
  // idle bus values at time zero
  initial begin
    reg_addr_o  = 8'hFF;
    reg_wr_o    = 1'b0;
    reg_wdata_o = 8'hFF;
    reg_rd_o    = 1'b0;
  end

  // ****************************************************************************
  // bus cycles
  // ****************************************************************************
  // one-cycle write strobe; on release address and data flip so stale values cannot pass
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_o  <= a;
    reg_wdata_o <= d;
    reg_wr_o    <= 1'b1;
    @(posedge clk_i);
    reg_wr_o    <= 1'b0;
    reg_addr_o  <= ~a;
    reg_wdata_o <= ~d;
  endtask

  // one-cycle read strobe; the answer is taken by the bench monitor
  task automatic read_reg(input logic [7:0] a);
    @(posedge clk_i);
    reg_addr_o <= a;
    reg_rd_o   <= 1'b1;
    @(posedge clk_i);
    reg_rd_o   <= 1'b0;
    reg_addr_o <= ~a;
  endtask
endmodule // reg_host_model

// ==== tb.sv ====
// self-checking bench for the identification, revision and interrupt mask register bank
`timescale 1ns/100ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  localparam logic [7:0]  MAKER   = 8'hC3; // arbitrary value
  localparam logic [3:0]  GEN     = 4'h6;  // arbitrary value
  localparam int unsigned REV_NUM = 3;
  typedef struct packed { logic [15:0] al; logic [15:0] pend; logic irq; logic [63:0] due; } anote_t;
  logic        clk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic [15:0] chan_alarm_i = 16'h0000;
  logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o, m1, m2, e;
  logic        reg_wr_i, reg_rd_i, reg_rdata_valid_o, irq_request_o;
  logic [15:0] chan_alarm_o, chan_irq_pending_o;
  int          err_count = 0;
  int          num_checks = 0;
  int          seed = 38677;
  logic [7:0]  rq[$];
  anote_t      aq[$];
  anote_t      n;

  always #12.5 clk_i = ~clk_i;

  id_rev_and_irq_mask_regs #(.MAKER_CODE(MAKER), .GENERATION_CODE(GEN), .REVISION_NUMBER(REV_NUM))
  u_id_rev_and_irq_mask_regs (.clk_i(clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .reg_rdata_valid_o(reg_rdata_valid_o), .chan_alarm_i(chan_alarm_i), .chan_alarm_o(chan_alarm_o),
    .chan_irq_pending_o(chan_irq_pending_o), .irq_request_o(irq_request_o));
  reg_host_model u_reg_host_model (.clk_i(clk_i), .reg_addr_o(reg_addr_i), .reg_wr_o(reg_wr_i),
    .reg_wdata_o(reg_wdata_i), .reg_rd_o(reg_rd_i));

  // ****************************************************************************
  // drivers that note expectations
  // ****************************************************************************
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] x);
    rq.push_back(x);
    u_reg_host_model.read_reg(a);
  endtask

  // each mask is read back right after its own write, with one idle cycle between
  task automatic set_masks(input logic [7:0] a, input logic [7:0] b);
    m1 = a;
    m2 = b;
    u_reg_host_model.write_reg(8'h18, a);
    rd_chk(8'h18, a);
    u_reg_host_model.write_reg(8'h19, b);
    rd_chk(8'h19, b);
  endtask

  // due time is 5 ns after the edge where the design samples the value, so the check falls on the falling edge half a cycle after it
  task automatic drive_alarm(input logic [15:0] v);
    anote_t t;
    @(posedge clk_i);
    chan_alarm_i <= v;
    t.al   = v;
    t.pend = v & ~{m2, m1};
    t.irq  = |t.pend;
    t.due  = $time + 30;
    aq.push_back(t);
  endtask

  task automatic report_and_stop;
    // a read or alarm note still queued means an answer never came
    `CHK(rq.size(), 0)
    `CHK(aq.size(), 0)
    $display("checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ****************************************************************************
  // monitor: oldest note against each result, sampled mid-cycle where outputs are settled
  // ****************************************************************************
  always @(negedge clk_i) begin
    if (reg_rdata_valid_o === 1'b1) begin
      e = (rq.size() > 0) ? rq.pop_front() : ~reg_rdata_o; // an unexpected answer must mismatch
      `CHK(reg_rdata_o, e)
    end
    if (aq.size() > 0 && aq[0].due <= $time) begin
      n = aq.pop_front();
      `CHK(chan_alarm_o, n.al)
      `CHK(chan_irq_pending_o, n.pend)
      `CHK(irq_request_o, n.irq)
    end
  end

  // watchdog sized well above the whole sequence
  initial begin
    #100000;
    err_count++;
    report_and_stop();
  end

  // ****************************************************************************
  // main sequence
  // ****************************************************************************
  initial begin
    m1 = 8'h00;
    m2 = 8'h00;
    repeat (16) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rd_chk(8'h16, MAKER);
    rd_chk(8'h17, {GEN, 4'(REV_NUM - 1)});
    rd_chk(8'h18, 8'h00);
    rd_chk(8'h19, 8'h00);
    rd_chk(8'h20, 8'h00);
    // read-only places ignore writes, including a write to an unmapped address
    u_reg_host_model.write_reg(8'h16, 8'h3C);
    rd_chk(8'h16, MAKER);
    u_reg_host_model.write_reg(8'h17, 8'hA5);
    rd_chk(8'h17, {GEN, 4'(REV_NUM - 1)});
    u_reg_host_model.write_reg(8'h20, 8'h77);
    rd_chk(8'h20, 8'h00);
    // walk a single mask bit over every channel with all alarms raised
    for (int i = 0; i < 16; i++) begin
      set_masks(8'(16'h0001 << i), 8'((16'h0001 << i) >> 8));
      drive_alarm(16'hFFFF);
      drive_alarm(16'h0000);
    end
    // random masks with readback and random alarm traffic
    repeat (12) begin
      set_masks(8'($random(seed)), 8'($random(seed)));
      rd_chk(8'h18, m1);
      rd_chk(8'h19, m2);
      repeat (3) drive_alarm(16'($random(seed)));
    end
    drive_alarm(16'h0000);
    repeat (3) @(posedge clk_i);
    // a second reset in mid-run must clear both masks
    reset_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    m1 = 8'h00;
    m2 = 8'h00;
    rd_chk(8'h18, 8'h00);
    rd_chk(8'h19, 8'h00);
    drive_alarm(16'hFFFF);
    drive_alarm(16'h0000);
    repeat (5) @(posedge clk_i);
    report_and_stop();
  end
endmodule // tb
